// file: common/ocp_defines.vh
// Purpose: Constants for the output compare PWM channel
// Assumes: 16-bit registers, word-indexed register port
// Notes: Offsets are register indexes on the plain register port
`ifndef OCP_DEFINES_VH
`define OCP_DEFINES_VH
// Register indexes
`define OCP_ADDR_W 3
`define OCP_REG_PERIOD 3'h0
`define OCP_REG_DUTY_BUF 3'h1
`define OCP_REG_DUTY_ACT 3'h2
`define OCP_REG_CHAN_CTRL 3'h3
`define OCP_REG_TMR_CTRL 3'h4
`define OCP_REG_COUNT 3'h5
`define OCP_REG_STATUS 3'h6
`define OCP_REG_MASK 3'h7
// Field positions
`define OCP_MODE_LSB 0
`define OCP_MODE_MSB 2
`define OCP_TMR_RUN_BIT 15
`define OCP_PRESC_LSB 4
`define OCP_PRESC_MSB 5
// Compare mode encodings
`define OCP_MODE_PWM_NOFAULT 3'h6
`define OCP_MODE_PWM_FAULT 3'h7
// Status bit positions
`define OCP_ST_PERIOD 0
`define OCP_ST_FAULT 1
`define OCP_ST_W 2
// Reset values
`define OCP_RST_WORD 16'h0000
`define OCP_RST_ST 2'h0
// Prescale codes: 1, 8, 64, 256
`define OCP_PRESC_1 2'h0
`define OCP_PRESC_8 2'h1
`define OCP_PRESC_64 2'h2
`define OCP_PRESC_256 2'h3
`define OCP_DIV_8 8'h07
`define OCP_DIV_64 8'h3f
`define OCP_DIV_256 8'hff
`define OCP_DIV_1 8'h00
`endif

// file: hdl/ocp_compare.v
// Purpose: Duty comparison deciding the PWM pin level
// Assumes: Count runs 0..period
// Notes: Purely combinational
`timescale 1ns/100ps
`default_nettype none
module ocp_compare #(
  parameter WIDTH = 16
) (
  input wire [WIDTH-1:0] count_i,
  input wire [WIDTH-1:0] duty_i,
  output wire high_o
);
  // ****************************************
  // Compare
  // ****************************************
  // High while count is below duty; zero duty never high, duty above
  // period always high, duty equal to period low for one count only
  assign high_o = (count_i < duty_i);
endmodule // ocp_compare
`default_nettype wire

// file: hdl/ocp_prescaler.v
// Purpose: Instruction-cycle and timer prescale enable pulses
// Assumes: One clock; instruction cycle is two clock periods
// Notes: Stops and clears while the timer is not running
`timescale 1ns/100ps
`default_nettype none
`include "ocp_defines.vh"
module ocp_prescaler (
  input wire clock_i,
  input wire reset_i,
  input wire run_i,
  input wire [1:0] presc_sel_i,
  output wire tick_o
);
  // ****************************************
  // Instruction cycle and prescale divider
  // ****************************************
  reg cyc_phase;
  reg [7:0] div_cnt;
  reg [7:0] div_limit;
  wire cyc_en;

  // Select prescale terminal count
  always @* begin
    case (presc_sel_i)
      `OCP_PRESC_8: div_limit = `OCP_DIV_8;
      `OCP_PRESC_64: div_limit = `OCP_DIV_64;
      `OCP_PRESC_256: div_limit = `OCP_DIV_256;
      default: div_limit = `OCP_DIV_1;
    endcase
  end

  // Two oscillator periods make one instruction cycle
  assign cyc_en = run_i & cyc_phase;

  // Phase toggle and prescale counter
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      cyc_phase <= 1'b0;
      div_cnt <= 8'h00;
    end else if (!run_i) begin
      cyc_phase <= 1'b0;
      div_cnt <= 8'h00;
    end else begin
      cyc_phase <= ~cyc_phase;
      if (cyc_en) begin
        if (div_cnt == div_limit)
          div_cnt <= 8'h00;
        else
          div_cnt <= div_cnt + 8'h01;
      end
    end
  end

  // One-cycle time base count enable
  assign tick_o = cyc_en & (div_cnt == div_limit);
endmodule // ocp_prescaler
`default_nettype wire

// file: hdl/ocp_pwm.v
// Purpose: Output compare channel in PWM mode with its time base
// Assumes: Plain register port, read data one cycle after read strobe
// Notes: Fault input only acts in the fault-enabled PWM mode
`timescale 1ns/100ps
`default_nettype none
`include "ocp_defines.vh"
module ocp_pwm #(
  parameter WIDTH = 16
) (
  input wire clock_i,
  input wire reset_i,
  input wire [`OCP_ADDR_W-1:0] addr_i,
  input wire [WIDTH-1:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [WIDTH-1:0] rdata_o,
  input wire fault_n_i,
  output reg pwm_output_pin_o,
  output wire irq_o
);
  // ****************************************
  // Registers
  // ****************************************
  reg [WIDTH-1:0] period_limit_reg;
  reg [WIDTH-1:0] duty_buffer_reg;
  reg [WIDTH-1:0] duty_active_reg;
  reg [2:0] compare_mode_field;
  reg timer_run_bit;
  reg [1:0] presc_sel;
  reg [WIDTH-1:0] time_base_count;
  reg [`OCP_ST_W-1:0] status;
  reg [`OCP_ST_W-1:0] irq_mask;
  reg fault_latched;
  reg [`OCP_ST_W-1:0] next_status;
  reg [WIDTH-1:0] rd_word;

  wire tick;
  wire pwm_mode;
  wire fault_mode;
  wire period_match;
  wire duty_high;
  wire fault_event;
  wire status_rd;
  wire [WIDTH-1:0] chan_ctrl_word;
  wire [WIDTH-1:0] tmr_ctrl_word;

  // ****************************************
  // Mode decode and time base
  // ****************************************
  // Two PWM encodings of the compare mode field
  assign fault_mode = (compare_mode_field == `OCP_MODE_PWM_FAULT);
  assign pwm_mode = (compare_mode_field == `OCP_MODE_PWM_NOFAULT) | fault_mode;
  assign period_match = (time_base_count == period_limit_reg);

  ocp_prescaler u_presc (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .run_i(timer_run_bit),
    .presc_sel_i(presc_sel),
    .tick_o(tick)
  );

  ocp_compare #(.WIDTH(WIDTH)) u_cmp (
    .count_i(time_base_count),
    .duty_i(duty_active_reg),
    .high_o(duty_high)
  );

  // Timer counts 0..period, then wraps
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i)
      time_base_count <= `OCP_RST_WORD;
    else if (wr_i && addr_i == `OCP_REG_COUNT)
      time_base_count <= wdata_i;
    else if (tick) begin
      if (period_match)
        time_base_count <= `OCP_RST_WORD;
      else
        time_base_count <= time_base_count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      period_limit_reg <= `OCP_RST_WORD;
      duty_buffer_reg <= `OCP_RST_WORD;
      duty_active_reg <= `OCP_RST_WORD;
      compare_mode_field <= 3'h0;
      timer_run_bit <= 1'b0;
      presc_sel <= `OCP_PRESC_1;
      irq_mask <= `OCP_RST_ST;
    end else begin
      if (wr_i) begin
        case (addr_i)
          `OCP_REG_PERIOD: period_limit_reg <= wdata_i;
          `OCP_REG_DUTY_BUF: duty_buffer_reg <= wdata_i;
          `OCP_REG_CHAN_CTRL: compare_mode_field <= wdata_i[`OCP_MODE_MSB:`OCP_MODE_LSB];
          `OCP_REG_TMR_CTRL: begin
            timer_run_bit <= wdata_i[`OCP_TMR_RUN_BIT];
            presc_sel <= wdata_i[`OCP_PRESC_MSB:`OCP_PRESC_LSB];
          end
          `OCP_REG_MASK: irq_mask <= wdata_i[`OCP_ST_W-1:0];
          default: ;
        endcase
      end
      // Direct write only outside PWM; held value starts the first period
      if (wr_i && addr_i == `OCP_REG_DUTY_ACT && !pwm_mode)
        duty_active_reg <= wdata_i;
      else if (pwm_mode && tick && period_match)
        duty_active_reg <= duty_buffer_reg;
    end
  end

  // ****************************************
  // Output pin and fault
  // ****************************************
  // Fault is an active-low input, acted on only in fault mode
  assign fault_event = fault_mode & ~fault_n_i & ~fault_latched;

  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      pwm_output_pin_o <= 1'b0;
      fault_latched <= 1'b0;
    end else begin
      // Fault clears when the mode is rewritten
      if (wr_i && addr_i == `OCP_REG_CHAN_CTRL)
        fault_latched <= 1'b0;
      else if (fault_event)
        fault_latched <= 1'b1;
      if (!pwm_mode || fault_latched || fault_event)
        pwm_output_pin_o <= 1'b0;
      else
        pwm_output_pin_o <= duty_high;
    end
  end

  // ****************************************
  // Interrupt status
  // ****************************************
  assign status_rd = rd_i & (addr_i == `OCP_REG_STATUS);

  // Sticky events; a new event wins over the read-clear
  always @* begin
    next_status = status;
    if (status_rd)
      next_status = `OCP_RST_ST;
    if (tick && period_match && pwm_mode)
      next_status[`OCP_ST_PERIOD] = 1'b1;
    if (fault_event)
      next_status[`OCP_ST_FAULT] = 1'b1;
  end

  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i)
      status <= `OCP_RST_ST;
    else
      status <= next_status;
  end

  assign irq_o = |(status & irq_mask);

  // ****************************************
  // Register reads
  // ****************************************
  assign chan_ctrl_word = {{(WIDTH-5){1'b0}}, fault_latched, 1'b0, compare_mode_field};
  assign tmr_ctrl_word = {timer_run_bit, {(WIDTH-7){1'b0}}, presc_sel, 4'h0};

  // Read mux
  always @* begin
    case (addr_i)
      `OCP_REG_PERIOD: rd_word = period_limit_reg;
      `OCP_REG_DUTY_BUF: rd_word = duty_buffer_reg;
      `OCP_REG_DUTY_ACT: rd_word = duty_active_reg;
      `OCP_REG_CHAN_CTRL: rd_word = chan_ctrl_word;
      `OCP_REG_TMR_CTRL: rd_word = tmr_ctrl_word;
      `OCP_REG_COUNT: rd_word = time_base_count;
      `OCP_REG_STATUS: rd_word = {{(WIDTH-`OCP_ST_W){1'b0}}, status};
      `OCP_REG_MASK: rd_word = {{(WIDTH-`OCP_ST_W){1'b0}}, irq_mask};
      default: rd_word = `OCP_RST_WORD;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i)
      rdata_o <= `OCP_RST_WORD;
    else if (rd_i)
      rdata_o <= rd_word;
    else
      rdata_o <= `OCP_RST_WORD;
  end
endmodule // ocp_pwm
`default_nettype wire

// file: verification/ocp_load.sv
// Purpose: Load on the PWM pin that counts high clocks
// Assumes: Window length given at the start pulse
// Notes: done_o pulses once with the final count
`timescale 1ns/100ps
`default_nettype none
module ocp_load (
  input wire logic clock_i,
  input wire logic pin_i,
  input wire logic start_i,
  input wire logic [15:0] win_i,
  output logic [15:0] high_o,
  output logic done_o
);
  logic [15:0] left = 16'h0000;
  // Sample the pin once per clock over the window
  always @(posedge clock_i) begin
    done_o <= (left == 16'h0001);
    if (start_i) begin
      left <= win_i;
      high_o <= 16'h0000;
    end else if (left != 16'h0000) begin
      left <= left - 16'h0001;
      high_o <= high_o + {15'h0000, pin_i};
    end
  end
endmodule // ocp_load
`default_nettype wire

// file: verification/ocp_pwm_monitor.sv
// Purpose: Port checker for the PWM channel
// Assumes: Register map and timing of the hand-over
// Notes: Shadows mode, mask and run bits from writes
`timescale 1ns/100ps
`default_nettype none
`include "ocp_defines.vh"
module ocp_pwm_monitor #(
  parameter WIDTH = 16
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [`OCP_ADDR_W-1:0] addr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [WIDTH-1:0] rdata_o,
  input wire logic fault_n_i,
  input wire logic pwm_output_pin_o,
  input wire logic irq_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  logic [2:0] mode_q;
  logic [1:0] mask_q;
  logic run_q;
  // Shadow copies of the fields software writes
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      mode_q <= 3'h0;
      mask_q <= 2'h0;
      run_q <= 1'b0;
    end else if (wr_i) begin
      if (addr_i == `OCP_REG_CHAN_CTRL) mode_q <= wdata_i[2:0];
      if (addr_i == `OCP_REG_MASK) mask_q <= wdata_i[1:0];
      if (addr_i == `OCP_REG_TMR_CTRL) run_q <= wdata_i[15];
    end
  end
  chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == '0)
    else $error("read data not zero outside read slot");
  chk_mode_back: assert property
    (rd_i && addr_i == `OCP_REG_CHAN_CTRL |=> rdata_o[2:0] == mode_q)
    else $error("mode field readback wrong");
  chk_pin_idle: assert property
    (mode_q[2:1] != 2'b11 |=> !pwm_output_pin_o) else $error("pin high outside pwm");
  chk_fault_force: assert property
    (mode_q == 3'h7 && !fault_n_i |=> !pwm_output_pin_o) else $error("fault did not drop pin");
  chk_fault_hold: assert property
    (mode_q == 3'h7 && !fault_n_i ##1 !(wr_i && addr_i == `OCP_REG_CHAN_CTRL) [*3]
    |-> !pwm_output_pin_o) else $error("fault latch lost");
  chk_irq_masked: assert property (mask_q == 2'h0 |-> !irq_o)
    else $error("irq with all masked");
  chk_irq_source: assert property
    (irq_o && rd_i && addr_i == `OCP_REG_STATUS |=> (rdata_o[1:0] & mask_q) != 2'h0)
    else $error("irq without unmasked status");
  chk_irq_clear: assert property
    (rd_i && addr_i == `OCP_REG_STATUS && !run_q && mode_q != 3'h7 |=> !irq_o)
    else $error("status read did not clear irq");
endmodule // ocp_pwm_monitor
`default_nettype wire

// file: verification/ocp_pwm_tb.sv
// Purpose: Self-checking bench for the PWM channel
// Assumes: Period 3, so one period is 8 clocks per prescale step
// Notes: Reads and load counts are checked from one queue
`timescale 1ns/100ps
`default_nettype none
`include "ocp_defines.vh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module ocp_pwm_tb;
  logic clock_i = 1'b0, reset_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, fault_n_i = 1'b1;
  logic start = 1'b0, rd_d = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [15:0] wdata_i = 16'h0000, win = 16'h0000, d, ev;
  wire logic [15:0] rdata_o, high;
  wire logic pwm_output_pin_o, irq_o, done;
  int n_fail = 0, num_checks = 0, i;
  int div[4] = '{1, 8, 64, 256};
  logic [15:0] exp_q[$];
  string name_q[$];
  string en;
  ocp_pwm i_ocp_pwm (.clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .fault_n_i(fault_n_i),
    .pwm_output_pin_o(pwm_output_pin_o), .irq_o(irq_o));
  ocp_load i_ocp_load (.clock_i(clock_i), .pin_i(pwm_output_pin_o), .start_i(start),
    .win_i(win), .high_o(high), .done_o(done));
  initial forever #25 clock_i = ~clock_i;
  task automatic wrap_up();
    if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic put(input logic [2:0] a, input logic [15:0] v, input logic w, input logic r);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= w;
    rd_i <= r;
    @(posedge clock_i);
  endtask
  task automatic wreg(input logic [2:0] a, input logic [15:0] v);
    put(a, v, 1'b1, 1'b0);
  endtask
  task automatic note(input logic [15:0] e, input string nm);
    exp_q.push_back(e);
    name_q.push_back(nm);
  endtask
  task automatic rreg(input logic [2:0] a, input logic [15:0] e, input string nm);
    note(e, nm);
    put(a, 16'h0000, 1'b0, 1'b1);
  endtask
  task automatic idle(input int n);
    put(addr_i, wdata_i, 1'b0, 1'b0);
    repeat (n - 1) @(posedge clock_i);
  endtask
  task automatic drain(input int n);
    for (int k = 0; k < n && exp_q.size() != 0; k++) @(posedge clock_i);
    if (exp_q.size() != 0) begin
      n_fail++;
      wrap_up();
    end
  endtask
  task automatic measure(input logic [15:0] w, input logic [15:0] e, input string nm);
    note(e, nm);
    start <= 1'b1;
    win <= w;
    idle(1);
    start <= 1'b0;
    drain(w + 8);
  endtask
  // Compare the oldest note when read data or a load count appears
  always @(posedge clock_i) begin
    rd_d <= rd_i;
    if (rd_d || done) begin
      en = name_q.pop_front();
      ev = exp_q.pop_front();
      `CHK(en, ev, (rd_d ? rdata_o : high))
    end
  end
  initial begin
    void'($urandom(32'h303a));
    repeat (8) @(posedge clock_i);
    reset_i <= 1'b0;
    for (i = 0; i < 8; i++) rreg(3'(i), 16'h0000, "reset value");
    wreg(`OCP_REG_PERIOD, 16'h0003);
    wreg(`OCP_REG_DUTY_BUF, 16'h0002);
    wreg(`OCP_REG_DUTY_ACT, 16'h0001);
    wreg(`OCP_REG_MASK, 16'h0003);
    wreg(`OCP_REG_CHAN_CTRL, {13'h0000, `OCP_MODE_PWM_NOFAULT});
    wreg(`OCP_REG_TMR_CTRL, 16'h8000);
    rreg(`OCP_REG_DUTY_ACT, 16'h0001, "first duty");
    for (i = 0; i < 6; i++) begin
      d = (i < 5) ? 16'(i) : 16'($urandom % 6);
      wreg(`OCP_REG_DUTY_BUF, d);
      idle(16);
      measure(16'd32, (d > 16'd4 ? 16'd4 : d) * 16'd8, "duty high");
    end
    wreg(`OCP_REG_DUTY_BUF, 16'h0001);
    for (i = 0; i < 4; i++) begin
      wreg(`OCP_REG_TMR_CTRL, 16'h8000 | 16'(i << 4));
      idle(16 * div[i]);
      measure(16'(8 * div[i]), 16'(2 * div[i]), "prescaled high");
    end
    wreg(`OCP_REG_TMR_CTRL, 16'h0000);
    wreg(`OCP_REG_DUTY_BUF, 16'h0003);
    wreg(`OCP_REG_DUTY_ACT, 16'h0002);
    rreg(`OCP_REG_DUTY_ACT, 16'h0001, "active held");
    wreg(`OCP_REG_TMR_CTRL, 16'h8000);
    idle(16);
    rreg(`OCP_REG_DUTY_ACT, 16'h0003, "active loaded");
    wreg(`OCP_REG_TMR_CTRL, 16'h0000);
    wreg(`OCP_REG_MASK, 16'h0000);
    idle(2);
    // Look at settled outputs half a period after the edge
    @(negedge clock_i);
    `CHK("irq masked", 1'b0, irq_o)
    @(posedge clock_i);
    wreg(`OCP_REG_MASK, 16'h0001);
    idle(1);
    @(negedge clock_i);
    `CHK("irq raised", 1'b1, irq_o)
    @(posedge clock_i);
    rreg(`OCP_REG_STATUS, 16'h0001, "period status");
    idle(2);
    @(negedge clock_i);
    `CHK("irq cleared", 1'b0, irq_o)
    @(posedge clock_i);
    wreg(`OCP_REG_MASK, 16'h0003);
    wreg(`OCP_REG_CHAN_CTRL, {13'h0000, `OCP_MODE_PWM_FAULT});
    fault_n_i <= 1'b0;
    idle(4);
    @(negedge clock_i);
    `CHK("fault pin", 1'b0, pwm_output_pin_o)
    `CHK("fault irq", 1'b1, irq_o)
    @(posedge clock_i);
    rreg(`OCP_REG_STATUS, 16'h0002, "fault status");
    rreg(`OCP_REG_CHAN_CTRL, 16'h0017, "fault latched");
    fault_n_i <= 1'b1;
    wreg(`OCP_REG_CHAN_CTRL, {13'h0000, `OCP_MODE_PWM_FAULT});
    rreg(`OCP_REG_CHAN_CTRL, 16'h0007, "latch cleared");
    idle(1);
    drain(8);
    wrap_up();
  end
endmodule // ocp_pwm_tb
bind ocp_pwm ocp_pwm_monitor #(.WIDTH(WIDTH)) i_ocp_pwm_monitor (.clock_i(clock_i),
  .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .fault_n_i(fault_n_i), .pwm_output_pin_o(pwm_output_pin_o),
  .irq_o(irq_o));
`default_nettype wire
